//--- rtl/lcr_field_split.v
// splits the applied compensation word into the loop code fields
`timescale 1ns/1ps
`default_nettype none
module lcr_field_split (
	input wire [39:0] comp,
	output wire [3:0] cur_int_cap,
	output wire cur_int_dbl,
	output wire [4:0] cur_filt_cap,
	output wire [5:0] cur_gain_res,
	output wire [3:0] volt_int_cap,
	output wire [4:0] volt_filt_cap,
	output wire [5:0] volt_gain_res,
	output wire [1:0] volt_gm,
	output wire [1:0] cur_gm
);
	// low two bits of each integrator code sit in the top pair of a higher byte
	assign cur_int_cap = {comp[25:24], comp[39:38]}; // see RL10
	assign cur_int_dbl = comp[32]; // see RL11
	assign cur_filt_cap = comp[37:33]; // see RL12
	assign cur_gain_res = comp[31:26]; // see RL13
	assign volt_int_cap = {comp[9:8], comp[23:22]}; // see RL14
	assign volt_filt_cap = comp[21:17]; // see RL15
	assign volt_gain_res = comp[15:10]; // see RL16
	assign volt_gm = comp[5:4]; // see RL17
	assign cur_gm = comp[1:0]; // see RL18
endmodule // lcr_field_split
`default_nettype wire

//--- rtl/lcr_map.vh
// command codes, field positions and widths for the loop configuration register slice
`ifndef LCR_MAP_VH
`define LCR_MAP_VH
`define LCR_CMD_PART_ID 8'hAD
`define LCR_CMD_SI_REV 8'hAE
`define LCR_CMD_LOOP_COMP 8'hB1
`define LCR_CMD_STORE_ALL 8'h15
`define LCR_CMD_RESTORE_ALL 8'h16
`define LCR_LEN_PART_ID 3'd6
`define LCR_LEN_SI_REV 3'd2
`define LCR_LEN_LOOP_COMP 3'd5
`define LCR_CML_IVC_BIT 7
`define LCR_COMP_RESERVED_MASK 40'h00_0001_00CC
`define LCR_PART_ID_VALUE 48'h0000_0000_0000
`define LCR_SI_REV_VALUE 16'h0000
`endif

//--- rtl/lcr_regs.v
// command register slice: identity, revision, loop compensation and write fault
//
// Operation
// RL1: read-only write sets summary and bit seven
// RL2: such fault raises host notification
// RL3: identifier sent low byte first, six bytes
// RL4: identifier command read block only
// RL5: revision two bytes, major minor subminor
// RL6: compensation five bytes, block read/write
// RL7: compensation starts from store or strap
// RL8: writes always taken, applied only when disabled
// RL9: host stores, clears override, restores to apply
// RL10: current integrator code from 25:24,39:38
// RL11: bit 32 doubles current integrator cap
// RL12: bits 37:33 current filter cap code
// RL13: bits 31:26 current gain resistor code
// RL14: voltage integrator code from 9:8,23:22
// RL15: bits 21:17 voltage filter cap code
// RL16: bits 15:10 voltage gain resistor code
// RL17: bits 5:4 voltage transconductance code
// RL18: bits 1:0 current transconductance code
// RL19: host writes reserved bits as zero
// RL20: read returns last written value
`timescale 1ns/1ps
`default_nettype none
`include "lcr_map.vh"
module lcr_regs #(
	parameter [47:0] PART_ID = `LCR_PART_ID_VALUE, // arbitrary neutral value
	parameter [15:0] SI_REV = `LCR_SI_REV_VALUE // arbitrary neutral value
) (
	input wire CORE_CLK,
	input wire RST_B,
	input wire CMD_START,
	input wire [7:0] CMD_CODE,
	input wire CMD_IS_WRITE,
	input wire WR_BYTE_VALID,
	input wire [7:0] WR_BYTE,
	input wire CMD_END,
	input wire RD_BYTE_REQ,
	input wire CONV_ENABLE,
	input wire INIT_LOAD,
	input wire [39:0] INIT_VALUE,
	input wire RESTORE_APPLY,
	input wire CML_CLEAR,
	output reg [7:0] RD_BYTE,
	output reg [2:0] RD_LEN,
	output reg COMM_FAULT_SUMMARY,
	output reg [7:0] STATUS_CML,
	output reg HOST_NOTIFY,
	output reg [39:0] COMP_READBACK,
	output reg [3:0] CUR_INT_CAP,
	output reg CUR_INT_DBL,
	output reg [4:0] CUR_FILT_CAP,
	output reg [5:0] CUR_GAIN_RES,
	output reg [3:0] VOLT_INT_CAP,
	output reg [4:0] VOLT_FILT_CAP,
	output reg [5:0] VOLT_GAIN_RES,
	output reg [1:0] VOLT_GM,
	output reg [1:0] CUR_GM
);
	////////////////////////////////////////////////////////////////////////////////
	// helpers
	function is_read_only;
		input [7:0] code;
		begin
			is_read_only = (code == `LCR_CMD_PART_ID) || (code == `LCR_CMD_SI_REV);
		end
	endfunction

	// decode of the one read/write block command
	function is_loop_comp;
		input [7:0] code;
		begin
			is_loop_comp = (code == `LCR_CMD_LOOP_COMP);
		end
	endfunction

	// byte of a block, zero past its end so an over-read never shows unknowns
	function [7:0] pick_byte;
		input [47:0] word;
		input [2:0] idx;
		begin
			if (idx < `LCR_LEN_PART_ID)
				pick_byte = word[idx*8 +: 8];
			else
				pick_byte = 8'h00;
		end
	endfunction

	// transaction state and the two copies of the compensation word
	reg [7:0] cur_cmd;
	reg cur_write;
	reg [2:0] byte_idx;
	reg [39:0] shadow;
	reg [39:0] applied;
	reg [39:0] next_shadow;
	reg pending_end;
	reg [7:0] next_rd_byte;
	reg [2:0] next_rd_len;
	// loop code fields from the splitter, ahead of their output registers
	wire [3:0] f_cii;
	wire f_cid;
	wire [4:0] f_cfc;
	wire [5:0] f_cgr;
	wire [3:0] f_vic;
	wire [4:0] f_vfc;
	wire [5:0] f_vgr;
	wire [1:0] f_vgm;
	wire [1:0] f_cgm;
	// decoded strobes of the current transaction
	wire ivc_event;
	wire byte_step;
	wire comp_byte_wr;
	wire comp_wr_end;

	////////////////////////////////////////////////////////////////////////////////
	// command tracking: code latched at start, byte index walks the block
	always @(posedge CORE_CLK)
	begin
		if (!RST_B)
		begin
			cur_cmd <= 8'h00;
			cur_write <= 1'b0;
			byte_idx <= 3'd0;
		end
		else if (CMD_START)
		begin
			cur_cmd <= CMD_CODE;
			cur_write <= CMD_IS_WRITE;
			byte_idx <= 3'd0;
		end
		else if (byte_step && byte_idx != 3'h7)
			byte_idx <= byte_idx + 3'd1; // saturates so a long block never wraps onto byte 0
	end

	// a read-only code with write direction is refused at start
	assign ivc_event = CMD_START && CMD_IS_WRITE && is_read_only(CMD_CODE); // see RL4
	// one byte moves in the direction the transaction was opened with
	assign byte_step = (WR_BYTE_VALID && cur_write) || (RD_BYTE_REQ && !cur_write);
	// bytes past the fifth of a compensation write are dropped
	assign comp_byte_wr = WR_BYTE_VALID && cur_write && is_loop_comp(cur_cmd)
		&& byte_idx < `LCR_LEN_LOOP_COMP;
	assign comp_wr_end = CMD_END && cur_write && is_loop_comp(cur_cmd);

	////////////////////////////////////////////////////////////////////////////////
	// compensation shadow: bytes land low first, extra bytes past five dropped
	always @*
	begin
		next_shadow = shadow;
		if (comp_byte_wr)
			next_shadow[byte_idx*8 +: 8] = WR_BYTE; // see RL6
	end

	// shadow always takes writes so a read shows the last one, blocked or not
	always @(posedge CORE_CLK)
	begin
		if (!RST_B)
			shadow <= 40'h00_0000_0000;
		else if (INIT_LOAD)
			shadow <= INIT_VALUE; // see RL7
		else
			shadow <= next_shadow; // see RL20
	end

	////////////////////////////////////////////////////////////////////////////////
	// applied word: follows a finished write only while conversion is off
	// a write taken while converting waits in the shadow for a restore
	always @(posedge CORE_CLK)
	begin
		if (!RST_B)
		begin
			applied <= 40'h00_0000_0000;
			pending_end <= 1'b0;
		end
		else
		begin
			pending_end <= comp_wr_end;
			if (INIT_LOAD)
				applied <= INIT_VALUE; // see RL7
			else if (RESTORE_APPLY)
				applied <= shadow; // see RL9
			else if (pending_end && !CONV_ENABLE)
				applied <= shadow; // see RL8
		end
	end

	lcr_field_split u_split (
		.comp(applied),
		.cur_int_cap(f_cii),
		.cur_int_dbl(f_cid),
		.cur_filt_cap(f_cfc),
		.cur_gain_res(f_cgr),
		.volt_int_cap(f_vic),
		.volt_filt_cap(f_vfc),
		.volt_gain_res(f_vgr),
		.volt_gm(f_vgm),
		.cur_gm(f_cgm)
	);

	// field outputs registered so the loop sees clean levels
	// costs one cycle of lag after the applied word changes
	always @(posedge CORE_CLK)
	begin
		if (!RST_B)
		begin
			CUR_INT_CAP <= 4'h0;
			CUR_INT_DBL <= 1'b0;
			CUR_FILT_CAP <= 5'h00;
			CUR_GAIN_RES <= 6'h00;
			VOLT_INT_CAP <= 4'h0;
			VOLT_FILT_CAP <= 5'h00;
			VOLT_GAIN_RES <= 6'h00;
			VOLT_GM <= 2'h0;
			CUR_GM <= 2'h0;
			COMP_READBACK <= 40'h00_0000_0000;
		end
		else
		begin
			CUR_INT_CAP <= f_cii; // see RL10
			CUR_INT_DBL <= f_cid; // see RL11
			CUR_FILT_CAP <= f_cfc; // see RL12
			CUR_GAIN_RES <= f_cgr; // see RL13
			VOLT_INT_CAP <= f_vic; // see RL14
			VOLT_FILT_CAP <= f_vfc; // see RL15
			VOLT_GAIN_RES <= f_vgr; // see RL16
			VOLT_GM <= f_vgm; // see RL17
			CUR_GM <= f_cgm; // see RL18
			COMP_READBACK <= shadow; // see RL20
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read path: byte 0 is bits 7:0, unknown codes read zero with length zero
	always @*
	begin
		next_rd_len = 3'h0;
		next_rd_byte = 8'h00;
		case (cur_cmd)
			`LCR_CMD_PART_ID:
			begin
				next_rd_len = `LCR_LEN_PART_ID;
				next_rd_byte = pick_byte(PART_ID, byte_idx); // see RL3
			end
			`LCR_CMD_SI_REV:
			begin
				next_rd_len = `LCR_LEN_SI_REV;
				next_rd_byte = pick_byte({32'h0000_0000, SI_REV}, byte_idx); // see RL5
			end
			`LCR_CMD_LOOP_COMP:
			begin
				next_rd_len = `LCR_LEN_LOOP_COMP;
				next_rd_byte = pick_byte({8'h00, shadow}, byte_idx); // see RL20
			end
			default:
			begin
				next_rd_len = 3'h0;
				next_rd_byte = 8'h00;
			end
		endcase
	end

	// registered so the byte a host samples never glitches while the index steps
	always @(posedge CORE_CLK)
	begin
		if (!RST_B)
		begin
			RD_BYTE <= 8'h00;
			RD_LEN <= 3'h0;
		end
		else
		begin
			RD_BYTE <= next_rd_byte;
			RD_LEN <= next_rd_len;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// fault flags: sticky, set beats a clear in the same cycle
	always @(posedge CORE_CLK)
	begin
		if (!RST_B)
		begin
			COMM_FAULT_SUMMARY <= 1'b0;
			STATUS_CML <= 8'h00;
			HOST_NOTIFY <= 1'b0;
		end
		else
		begin
			HOST_NOTIFY <= ivc_event; // see RL2
			// a clear landing with a new fault loses, so no fault goes unseen
			if (ivc_event)
			begin
				COMM_FAULT_SUMMARY <= 1'b1; // see RL1
				STATUS_CML[`LCR_CML_IVC_BIT] <= 1'b1; // see RL1
			end
			else if (CML_CLEAR)
			begin
				COMM_FAULT_SUMMARY <= 1'b0;
				STATUS_CML <= 8'h00;
			end
		end
	end
endmodule // lcr_regs
`default_nettype wire

//--- testbench/lcr_host.sv
// host model that runs command transactions into the register slice
`timescale 1ns/1ps
`default_nettype none
`include "lcr_map.vh"
module lcr_host (
	input wire logic clk,
	input wire logic [7:0] rd_byte,
	output logic start,
	output logic is_wr,
	output logic wr_valid,
	output logic stop,
	output logic rd_req,
	output logic [7:0] code,
	output logic [7:0] wr_byte
);
	initial
	begin
		{start, is_wr, wr_valid, stop, rd_req, code, wr_byte} = 0;
	end
	////////////////////////////////////////
	// one transaction: writes send n bytes of d low byte first, reads fill d
	task automatic xfer(logic [7:0] c, logic w, int n, inout logic [47:0] d);
		if (c == `LCR_CMD_LOOP_COMP)
			d[39:0] &= ~`LCR_COMP_RESERVED_MASK;
		@(posedge clk) start <= 1;
		code <= c;
		is_wr <= w;
		@(posedge clk) start <= 0;
		for (int i = 0; i < n; i++)
		begin
			if (w)
			begin
				wr_valid <= 1;
				wr_byte <= d[8*i +: 8];
				@(posedge clk);
			end
			else
			begin
				repeat (3) @(negedge clk);
				d[8*i +: 8] = rd_byte;
				@(posedge clk) rd_req <= 1;
				@(posedge clk) rd_req <= 0;
			end
		end
		wr_valid <= 0;
		wr_byte <= ~wr_byte; // released line must not keep the last byte
		stop <= 1;
		@(posedge clk) stop <= 0;
	endtask
endmodule // lcr_host
`default_nettype wire

//--- testbench/lcr_regs_properties.sv
// checker for the fault flags and block lengths of the register slice
`timescale 1ns/1ps
`default_nettype none
module lcr_regs_properties (
	input wire logic CORE_CLK,
	input wire logic RST_B,
	input wire logic CMD_START,
	input wire logic CMD_IS_WRITE,
	input wire logic [7:0] CMD_CODE,
	input wire logic CML_CLEAR,
	input wire logic COMM_FAULT_SUMMARY,
	input wire logic [7:0] STATUS_CML,
	input wire logic HOST_NOTIFY,
	input wire logic [2:0] RD_LEN
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);
	////////////////////////////////////////
	// a write aimed at one of the two read-only commands, and a read start
	wire ro_wr = CMD_START & CMD_IS_WRITE & (CMD_CODE == 8'hAD | CMD_CODE == 8'hAE);
	wire rd_go = CMD_START & !CMD_IS_WRITE;
	a_ivc_flags_set: assert property (ro_wr |=> STATUS_CML[7] && COMM_FAULT_SUMMARY)
		else $error("fault flags not set");
	a_ivc_flag_sticky: assert property (STATUS_CML[7] && !CML_CLEAR |=> STATUS_CML[7])
		else $error("fault flag lost");
	a_summary_follows: assert property (STATUS_CML[7] |-> COMM_FAULT_SUMMARY)
		else $error("summary bit missing");
	a_ivc_notify: assert property (ro_wr |=> HOST_NOTIFY)
		else $error("no host notify");
	a_notify_cause: assert property (HOST_NOTIFY |-> $past(ro_wr))
		else $error("stray host notify");
	a_id_len: assert property (rd_go && CMD_CODE == 8'hAD |-> ##2 RD_LEN == 3'd6)
		else $error("bad identifier length");
	a_rev_len: assert property (rd_go && CMD_CODE == 8'hAE |-> ##2 RD_LEN == 3'd2)
		else $error("bad revision length");
	a_comp_len: assert property (CMD_START && CMD_CODE == 8'hB1 |-> ##2 RD_LEN == 3'd5)
		else $error("bad compensation length");
	c_fault: cover property (ro_wr);
	c_clear: cover property (STATUS_CML[7] && CML_CLEAR);
	c_id_read: cover property (rd_go && CMD_CODE == 8'hAD);
endmodule // lcr_regs_properties
bind lcr_regs lcr_regs_properties u_props (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
	.CMD_START(CMD_START), .CMD_IS_WRITE(CMD_IS_WRITE), .CMD_CODE(CMD_CODE),
	.CML_CLEAR(CML_CLEAR), .COMM_FAULT_SUMMARY(COMM_FAULT_SUMMARY),
	.STATUS_CML(STATUS_CML), .HOST_NOTIFY(HOST_NOTIFY), .RD_LEN(RD_LEN));
`default_nettype wire

//--- testbench/lcr_regs_tb.sv
// self-checking bench for the loop configuration register slice
`timescale 1ns/1ps
`default_nettype none
`include "lcr_map.vh"
module lcr_regs_tb;
	localparam [47:0] ID = 48'h0123_4567_89AB; // arbitrary test value
	localparam [15:0] REV = 16'h5A3C; // arbitrary test value
	logic clk = 0, rst_b = 0, conv_en = 0, init_load = 0, restore = 0, cml_clear = 0;
	logic [39:0] init_value = 0;
	wire [7:0] rd_byte, cmd_code, wr_byte, comm_fault_summary_bit;
	wire start, is_wr, wr_valid, stop, rd_req, summary, notify;
	wire [39:0] readback;
	wire [34:0] f;
	int err_count = 0, compares = 0, notes = 0;
	lcr_regs #(.PART_ID(ID), .SI_REV(REV)) dut (.CORE_CLK(clk), .RST_B(rst_b),
		.CMD_START(start), .CMD_CODE(cmd_code), .CMD_IS_WRITE(is_wr), .WR_BYTE_VALID(wr_valid),
		.WR_BYTE(wr_byte), .CMD_END(stop), .RD_BYTE_REQ(rd_req), .CONV_ENABLE(conv_en),
		.INIT_LOAD(init_load), .INIT_VALUE(init_value), .RESTORE_APPLY(restore),
		.CML_CLEAR(cml_clear), .RD_BYTE(rd_byte), .RD_LEN(), .COMM_FAULT_SUMMARY(summary),
		.STATUS_CML(comm_fault_summary_bit), .HOST_NOTIFY(notify), .COMP_READBACK(readback),
		.CUR_INT_CAP(f[34:31]), .CUR_INT_DBL(f[30]), .CUR_FILT_CAP(f[29:25]),
		.CUR_GAIN_RES(f[24:19]), .VOLT_INT_CAP(f[18:15]), .VOLT_FILT_CAP(f[14:10]),
		.VOLT_GAIN_RES(f[9:4]), .VOLT_GM(f[3:2]), .CUR_GM(f[1:0]));
	lcr_host host (.clk(clk), .rd_byte(rd_byte), .start(start), .is_wr(is_wr),
		.wr_valid(wr_valid), .stop(stop), .rd_req(rd_req), .code(cmd_code), .wr_byte(wr_byte));
	////////////////////////////////////////
	always #4 clk = ~clk;
	// counts notification pulses seen by the host
	always @(posedge clk) notes += notify;
	// field outputs in port order, worked out from a compensation word
	function automatic [34:0] split(input [39:0] v);
		split = {v[25:24], v[39:38], v[32], v[37:33], v[31:26], v[9:8], v[23:22], v[21:17],
			v[15:10], v[5:4], v[1:0]};
	endfunction
	task automatic check(string what, logic [79:0] seen, logic [79:0] want);
		compares++;
		if (seen !== want)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic final_report;
		if (err_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// writes to both read-only commands, each fault then cleared
	task automatic t_fault;
		logic [47:0] d = 48'hFF;
		for (int k = 1; k < 3; k++)
		begin
			host.xfer(k == 1 ? `LCR_CMD_PART_ID : `LCR_CMD_SI_REV, 1, 1, d);
			check("fault", {summary, comm_fault_summary_bit[7], notes[1:0]}, {2'b11, k[1:0]});
			@(posedge clk) cml_clear <= 1;
			@(posedge clk) cml_clear <= 0;
			@(negedge clk);
			check("cleared", {summary, comm_fault_summary_bit}, 0);
		end
	endtask
	// identity reads after the refused writes
	task automatic t_ident;
		logic [47:0] d = 0;
		host.xfer(`LCR_CMD_PART_ID, 0, 6, d);
		check("id", d, ID);
		d = 0;
		host.xfer(`LCR_CMD_SI_REV, 0, 2, d);
		check("rev", d, REV);
	endtask
	// compensation: applied when off, held when on, then restore and initial load
	task automatic t_comp;
		logic [39:0] a = 40'hD7_A9E4_3833, b = 40'h2C_5B7A_C622;
		logic [47:0] d = {8'h0, a};
		host.xfer(`LCR_CMD_LOOP_COMP, 1, 5, d);
		repeat (4) @(negedge clk);
		check("applied", f, split(a));
		d = 0;
		host.xfer(`LCR_CMD_LOOP_COMP, 0, 5, d);
		check("readback", d, a);
		@(posedge clk) conv_en <= 1;
		d = {8'h0, b};
		host.xfer(`LCR_CMD_LOOP_COMP, 1, 5, d);
		repeat (4) @(negedge clk);
		check("blocked", {readback, f}, {b, split(a)});
		host.xfer(`LCR_CMD_STORE_ALL, 1, 0, d);
		@(posedge clk) restore <= 1;
		@(posedge clk) restore <= 0;
		repeat (3) @(negedge clk);
		check("restored", f, split(b));
		@(posedge clk) init_value <= a;
		init_load <= 1;
		@(posedge clk) init_load <= 0;
		repeat (3) @(negedge clk);
		check("initial", {readback, f}, {a, split(a)});
		// a sixth byte is dropped, still blocked from the loop while converting
		d = {8'hFF, b};
		host.xfer(`LCR_CMD_LOOP_COMP, 1, 6, d);
		repeat (3) @(negedge clk);
		check("long write", {readback, f}, {b, split(a)});
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		rst_b <= 1;
		t_fault;
		t_ident;
		t_comp;
		final_report;
	end
	// watchdog far beyond the roughly 150 cycles the tests need
	initial
	begin
		#100000;
		err_count++;
		final_report;
	end
endmodule // lcr_regs_tb
`default_nettype wire
